// [rtl/irq_regs_pkg.sv]
`default_nettype none
package irq_regs_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses on the APB bus)
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_FLAGS_0 = 12'h000;
   localparam logic [11:0] ADDR_FLAGS_1 = 12'h004;
   localparam logic [11:0] ADDR_FLAGS_2 = 12'h008;
   localparam logic [11:0] ADDR_ENABLES_0 = 12'h00c;
   localparam logic [11:0] ADDR_ENABLES_1 = 12'h010;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h014;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;

   // ------------------------------------------------------------
   // Widths, reset values and implemented-bit masks
   // ------------------------------------------------------------
   localparam int REG_W = 16;
   localparam int NUM_SRC = 80;
   localparam logic [15:0] FLAGS_RST = 16'h0000;
   localparam logic [15:0] ENABLES_RST = 16'h0000;
   localparam logic [15:0] FLAGS_2_IMPL = 16'h1fff;
   localparam logic [2:0] IRQ_EVT_RST = 3'h0;

   // Fixed bit positions of the named sources
   localparam int EXT_IRQ0_BIT = 0;
   localparam int CAPTURE1_BIT = 1;

   // Sticky event bits of the block's own status register
   localparam int EVT_NEW_PEND = 0;
   localparam int EVT_RAISED = 1;
   localparam int EVT_BAD_ADDR = 2;
endpackage
`default_nettype wire

// [rtl/irq_flag_bank.sv]
`default_nettype none
// One 16-bit bank of request flags with separate set and clear strobes
module irq_flag_bank
   import irq_regs_pkg::*;
#(
   parameter logic [15:0] IMPL = 16'hffff
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [15:0] set_i,
   input wire logic [15:0] clr_i,
   output logic [15:0] flags_o
);
   logic [15:0] flags_r;
   logic [15:0] flags_nxt;

   // Set wins over a clear in the same cycle so no event is lost
   always_comb begin
      flags_nxt = ((flags_r & ~clr_i) | set_i) & IMPL;
   end

   // Only the software clear strobe or srst_i brings a flag back to zero
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         flags_r <= FLAGS_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags_o = flags_r;
endmodule
`default_nettype wire

// [rtl/irq_pend_gate.sv]
`default_nettype none
// Per-source gating of flag by enable, registered
module irq_pend_gate (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [15:0] flags_i,
   input wire logic [15:0] enables_i,
   output logic [15:0] pend_o,
   output logic any_o
);
   logic [15:0] pend_r;
   logic [15:0] pend_nxt;
   logic any_r;
   logic any_nxt;

   // Each enable gates exactly its own flag, bit for bit
   always_comb begin
      pend_nxt = flags_i & enables_i;
      any_nxt = |pend_nxt;
   end

   // Registered so the arbiter sees glitch-free requests
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pend_r <= 16'h0000;
         any_r <= 1'b0;
      end else begin
         pend_r <= pend_nxt;
         any_r <= any_nxt;
      end
   end

   assign pend_o = pend_r;
   assign any_o = any_r;
endmodule
`default_nettype wire

// [rtl/irq_flag_enable_regs.sv]
// The placing of the registers and the APB register port were chosen for this implementation.
`default_nettype none
// Behaviour
// - Flag reads 1 after its request, else 0
// - Enable 1 passes request, 0 blocks it; flags2 requests are always blocked here
// - Flags0 bit1 capture1, bit0 external irq0
// - Flags1 15..8 capture6..3, can1, spi2, uart2
// - Flags1 7..0 ext2, timers, compares, captures, ext1
// - Flags2 15..13 read zero, 12..4 sources
// - Flags2 3..0 compare8..5, read/write, reset 0
// - Enables0 bits 15..0 in source order
// - Enables0 bit0 ext irq0, bit1 capture1
// - Source sets flag; only software clears it
// - Each enable gates exactly one source
// - Bit positions follow vector source order
module irq_flag_enable_regs
   import irq_regs_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Request pulses from peripherals, bit order as vector order
   input wire logic [15:0] src0_i,
   input wire logic [15:0] src1_i,
   input wire logic [15:0] src2_i,
   // Gated requests towards priority arbitration
   output logic [15:0] pend0_o,
   output logic [15:0] pend1_o,
   output logic [15:0] pend2_o,
   output logic pend_any_o,
   output logic irq_o
);
   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic acc;
   logic wr;
   logic rd;
   logic hit;
   logic lo_we;
   logic hi_we;
   logic [15:0] wmask;
   logic [15:0] wval;

   // Access phase; registers answer with zero wait states
   always_comb begin
      acc = psel_i & penable_i;
      wr = acc & pwrite_i;
      rd = acc & ~pwrite_i;
      lo_we = pstrb_i[0];
      hi_we = pstrb_i[1];
      wmask = {{8{hi_we}}, {8{lo_we}}};
      wval = pwdata_i[15:0];
      hit = (paddr_i == ADDR_FLAGS_0) | (paddr_i == ADDR_FLAGS_1) |
            (paddr_i == ADDR_FLAGS_2) | (paddr_i == ADDR_ENABLES_0) |
            (paddr_i == ADDR_ENABLES_1) | (paddr_i == ADDR_IRQ_STATUS) |
            (paddr_i == ADDR_IRQ_MASK);
   end

   // ------------------------------------------------------------
   // Flag banks
   // ------------------------------------------------------------
   logic [15:0] clr0;
   logic [15:0] clr1;
   logic [15:0] clr2;
   logic [15:0] flags0;
   logic [15:0] flags1;
   logic [15:0] flags2;
   logic [15:0] set0;
   logic [15:0] set1;
   logic [15:0] set2;
   logic [15:0] sw_set0;
   logic [15:0] sw_set1;
   logic [15:0] sw_set2;

   // Flags are read/write: a write stores the value in the lanes written.
   // A written zero clears; a written one sets, like a software request.
   always_comb begin
      sw_set0 = '0;
      sw_set1 = '0;
      sw_set2 = '0;
      clr0 = '0;
      clr1 = '0;
      clr2 = '0;
      if (wr && paddr_i == ADDR_FLAGS_0) begin
         sw_set0 = wval & wmask;
         clr0 = ~wval & wmask;
      end
      if (wr && paddr_i == ADDR_FLAGS_1) begin
         sw_set1 = wval & wmask;
         clr1 = ~wval & wmask;
      end
      if (wr && paddr_i == ADDR_FLAGS_2) begin
         sw_set2 = wval & wmask;
         clr2 = ~wval & wmask;
      end
      // Bit i of each source vector lands on flag bit i
      set0 = src0_i | sw_set0;
      set1 = src1_i | sw_set1;
      set2 = src2_i | sw_set2;
   end

   irq_flag_bank #(.IMPL(16'hffff)) u_flags0 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .set_i(set0),
      .clr_i(clr0),
      .flags_o(flags0)
   );

   irq_flag_bank #(.IMPL(16'hffff)) u_flags1 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .set_i(set1),
      .clr_i(clr1),
      .flags_o(flags1)
   );

   // Top three bits not implemented, read as zero
   irq_flag_bank #(.IMPL(FLAGS_2_IMPL)) u_flags2 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .set_i(set2),
      .clr_i(clr2),
      .flags_o(flags2)
   );

   // ------------------------------------------------------------
   // Enable registers
   // ------------------------------------------------------------
   logic [15:0] en0_r;
   logic [15:0] en0_nxt;
   logic [15:0] en1_r;
   logic [15:0] en1_nxt;
   logic [15:0] en2;

   // Plain byte-lane writes, no side effects
   always_comb begin
      en0_nxt = en0_r;
      en1_nxt = en1_r;
      if (wr && paddr_i == ADDR_ENABLES_0) begin
         en0_nxt = (en0_r & ~wmask) | (wval & wmask);
      end
      if (wr && paddr_i == ADDR_ENABLES_1) begin
         en1_nxt = (en1_r & ~wmask) | (wval & wmask);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         en0_r <= ENABLES_RST;
         en1_r <= ENABLES_RST;
      end else begin
         en0_r <= en0_nxt;
         en1_r <= en1_nxt;
      end
   end

   // The third enable register lies outside this block; its sources
   // are held disabled here so they never reach arbitration.
   assign en2 = 16'h0000;

   // ------------------------------------------------------------
   // Gating toward arbitration
   // ------------------------------------------------------------
   logic any0;
   logic any1;
   logic any2;

   irq_pend_gate u_gate0 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .flags_i(flags0),
      .enables_i(en0_r),
      .pend_o(pend0_o),
      .any_o(any0)
   );

   irq_pend_gate u_gate1 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .flags_i(flags1),
      .enables_i(en1_r),
      .pend_o(pend1_o),
      .any_o(any1)
   );

   irq_pend_gate u_gate2 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .flags_i(flags2),
      .enables_i(en2),
      .pend_o(pend2_o),
      .any_o(any2)
   );

   // ------------------------------------------------------------
   // Block interrupt: sticky events, mask, level output
   // ------------------------------------------------------------
   logic [2:0] evt_r;
   logic [2:0] evt_nxt;
   logic [2:0] mask_r;
   logic [2:0] mask_nxt;
   logic any_now;
   logic any_d_r;
   logic any_d_nxt;
   logic [15:0] newbits;
   logic [2:0] evt_set;
   logic irq_r;
   logic irq_nxt;
   logic pend_any_r;

   // Events: a source setting a clear flag, pending rising, bad bus address.
   // Set beats the write-one clear issued in the same cycle.
   always_comb begin
      any_now = any0 | any1 | any2;
      any_d_nxt = any_now;
      newbits = (src0_i & ~flags0) | (src1_i & ~flags1) |
                (src2_i & ~flags2 & FLAGS_2_IMPL);
      evt_set = '0;
      evt_set[EVT_NEW_PEND] = |newbits;
      evt_set[EVT_RAISED] = any_now & ~any_d_r;
      evt_set[EVT_BAD_ADDR] = acc & ~hit;
      evt_nxt = evt_r;
      mask_nxt = mask_r;
      if (wr && lo_we && paddr_i == ADDR_IRQ_STATUS) begin
         evt_nxt = evt_r & ~pwdata_i[2:0];
      end
      if (wr && lo_we && paddr_i == ADDR_IRQ_MASK) begin
         mask_nxt = pwdata_i[2:0];
      end
      evt_nxt = evt_nxt | evt_set;
      irq_nxt = |(evt_nxt & mask_nxt);
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         evt_r <= IRQ_EVT_RST;
         mask_r <= IRQ_EVT_RST;
         any_d_r <= 1'b0;
         irq_r <= 1'b0;
         pend_any_r <= 1'b0;
      end else begin
         evt_r <= evt_nxt;
         mask_r <= mask_nxt;
         any_d_r <= any_d_nxt;
         irq_r <= irq_nxt;
         pend_any_r <= any_now;
      end
   end

   assign irq_o = irq_r;
   assign pend_any_o = pend_any_r;

   // ------------------------------------------------------------
   // Read data and response
   // ------------------------------------------------------------
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic err_nxt;

   // Data are registered in the setup cycle so the access phase
   // completes at once; unmapped addresses answer with an error.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (paddr_i)
         ADDR_FLAGS_0: rdata_nxt = {16'h0000, flags0};
         ADDR_FLAGS_1: rdata_nxt = {16'h0000, flags1};
         ADDR_FLAGS_2: rdata_nxt = {16'h0000, flags2};
         ADDR_ENABLES_0: rdata_nxt = {16'h0000, en0_r};
         ADDR_ENABLES_1: rdata_nxt = {16'h0000, en1_r};
         ADDR_IRQ_STATUS: rdata_nxt = {29'h0, evt_r};
         ADDR_IRQ_MASK: rdata_nxt = {29'h0, mask_r};
         default: rdata_nxt = 32'h0000_0000;
      endcase
      if (!(psel_i && !penable_i && !pwrite_i)) begin
         rdata_nxt = rdata_r;
      end
      err_nxt = psel_i & ~penable_i & ~hit;
   end

   logic err_r;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         err_r <= err_nxt;
      end
   end

   // Ready is a constant high flop: every access takes one phase
   logic ready_r;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= 1'b1;
      end
   end

   assign prdata_o = rdata_r;
   assign pready_o = ready_r;
   assign pslverr_o = err_r;
endmodule
`default_nettype wire

// [tb/irq_flag_enable_regs_assertions.sv]
`default_nettype none
module irq_checker
   import irq_regs_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [15:0] src0_i,
   input wire logic [15:0] pend0_o,
   input wire logic [15:0] pend1_o,
   input wire logic [15:0] pend2_o,
   input wire logic pend_any_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   logic acc, bad, wr0, src_any;
   // Only sources and writes to flags0 or enables0 may move pend0
   assign acc = psel_i && penable_i;
   // Any address off the register map is refused, misaligned ones too
   assign bad = !(paddr_i == ADDR_FLAGS_0 || paddr_i == ADDR_FLAGS_1 ||
      paddr_i == ADDR_FLAGS_2 || paddr_i == ADDR_ENABLES_0 ||
      paddr_i == ADDR_ENABLES_1 || paddr_i == ADDR_IRQ_STATUS ||
      paddr_i == ADDR_IRQ_MASK);
   assign wr0 = acc && pwrite_i && (paddr_i == ADDR_FLAGS_0 ||
      paddr_i == ADDR_ENABLES_0);
   assign src_any = |src0_i;
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_read;
      acc && !pwrite_i;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_ready_next:
      assert property (s_setup |=> pready_o)
      else $error("access phase without ready");
   a_err_bad:
      assert property (acc && bad |-> pslverr_o)
      else $error("unmapped access not refused");
   a_err_cause:
      assert property (pslverr_o |-> acc && bad)
      else $error("error on a mapped access");
   a_upper_zero:
      assert property (s_read |-> prdata_o[31:16] == 16'h0)
      else $error("upper read data not zero");
   a_flags2_top:
      assert property (s_read ##0 paddr_i == ADDR_FLAGS_2 |->
         prdata_o[15:13] == 3'h0)
      else $error("flags2 top bits not zero");
   a_pend2_zero:
      assert property (pend2_o == 16'h0)
      else $error("pend2 without enable register");
   // A reset between samples would make the OR look stale
   a_any_or:
      assert property (!$past(srst_i) |-> pend_any_o ==
         ($past(pend0_o) != 16'h0 || $past(pend1_o) != 16'h0))
      else $error("pend_any not OR of pending");
   // Cause reaches the flag at one edge and the pending flop at the next
   a_pend_rise:
      assert property ((pend0_o & ~$past(pend0_o)) != 16'h0 |->
         $past(src_any, 2) || $past(wr0, 2))
      else $error("pend0 rose without cause");
   a_pend_fall:
      assert property ((~pend0_o & $past(pend0_o)) != 16'h0 |->
         $past(wr0, 2))
      else $error("pend0 fell without software");
endmodule

bind irq_flag_enable_regs irq_checker u_chk (
   .core_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .prdata_o, .pready_o, .pslverr_o, .src0_i, .pend0_o, .pend1_o,
   .pend2_o, .pend_any_o
);
`default_nettype wire

// [tb/periph_model.sv]
`default_nettype none
module periph_model (
   input wire logic core_clk_i,
   output logic [15:0] src0_o,
   output logic [15:0] src1_o,
   output logic [15:0] src2_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // No request at time zero
   initial begin
      {src2_o, src1_o, src0_o} = 48'h0;
   end
   // One-cycle pulse; the flag has to keep it afterwards
   task automatic raise(input int b, input int k);
      logic [47:0] v;
      v = 48'h1 << (16 * b + k);
      @(posedge core_clk_i);
      {src2_o, src1_o, src0_o} <= v;
      @(posedge core_clk_i);
      {src2_o, src1_o, src0_o} <= 48'h0;
   endtask
endmodule
`default_nettype wire

// [tb/test_interrupt_flag_enable_regs.sv]
`default_nettype none
module test_interrupt_flag_enable_regs
   import irq_regs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0;
   logic penable_i = 1'b0, pwrite_i = 1'b0, err;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic [3:0] pstrb_i = 4'hf, strb = 4'hf;
   logic pready_o, pslverr_o, pend_any_o, irq_o;
   logic [15:0] src0_i, src1_i, src2_i, pend0_o, pend1_o, pend2_o, f, e;
   int err_count = 0, n_tests = 0;

   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end

   irq_flag_enable_regs u_dut (.core_clk_i, .srst_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
      .pslverr_o, .src0_i, .src1_i, .src2_i, .pend0_o, .pend1_o,
      .pend2_o, .pend_any_o, .irq_o);
   periph_model u_per (.core_clk_i, .src0_o(src0_i), .src1_o(src1_i),
      .src2_o(src2_i));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until ready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= strb;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      // Read right after the edge: these are the values the slave showed
      // at that edge, since its own flops update only afterwards
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 16);
      if (pready_o !== 1'b1) begin
         err_count++;
         $display("ERROR %0t: no ready from the slave", $time);
         close_out();
      end else begin
         rd = prdata_o;
         err = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(rd, x);
   endtask

   // Registered outputs: let two edges land before looking
   task automatic irq_is(input logic x);
      repeat (2) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk(32'(irq_o), 32'(x));
   endtask

   // Top three flags2 sources have no storage
   function automatic logic [15:0] flag_exp(int b, int k);
      return (b == 2 && k > 12) ? 16'h0 : 16'h1 << k;
   endfunction

   initial begin
      void'($urandom(32'h5065935b));
      repeat (4) @(posedge core_clk_i);
      srst_i <= 1'b0;
      for (int a = 0; a <= 24; a += 4) rdc(12'(a), 32'h0);
      apb(1'b0, 12'h01c, 32'h0);
      chk(rd, 32'h0);
      chk(32'(err), 32'h1);
      $display("test reset done");
      f = 16'($urandom);
      e = 16'($urandom);
      apb(1'b1, ADDR_FLAGS_1, {16'hffff, f});
      rdc(ADDR_FLAGS_1, {16'h0, f});
      apb(1'b1, ADDR_FLAGS_2, 32'hffff);
      rdc(ADDR_FLAGS_2, 32'h1fff);
      apb(1'b1, ADDR_ENABLES_0, {16'h0, e});
      rdc(ADDR_ENABLES_0, {16'h0, e});
      strb = 4'h1;
      apb(1'b1, ADDR_ENABLES_1, 32'hffff);
      strb = 4'hf;
      rdc(ADDR_ENABLES_1, 32'h00ff);
      $display("test access done");
      // Each source but flags2 bits 15..13 reaches its own flag and stays there
      for (int b = 0; b < 3; b++) begin
         for (int k = 0; k < 16; k++) begin
            apb(1'b1, 12'(4 * b), 32'h0);
            u_per.raise(b, k);
            repeat (3) @(posedge core_clk_i);
            rdc(12'(4 * b), {16'h0, flag_exp(b, k)});
         end
      end
      $display("test sources done");
      for (int i = 0; i < 6; i++) begin
         f = (i == 0) ? 16'hffff : 16'($urandom);
         e = (i == 0) ? 16'h0 : (i == 1) ? 16'hffff : 16'($urandom);
         apb(1'b1, ADDR_FLAGS_0, {16'h0, f});
         apb(1'b1, ADDR_ENABLES_0, {16'h0, e});
         apb(1'b1, ADDR_FLAGS_1, {16'h0, ~e});
         apb(1'b1, ADDR_ENABLES_1, {16'h0, f});
         repeat (3) @(posedge core_clk_i);
         @(negedge core_clk_i);
         chk({pend1_o, pend0_o}, {~e & f, f & e});
         chk({pend_any_o, pend2_o}, {(f & e) != 0 || (~e & f) != 0, 16'h0});
      end
      $display("test gating done");
      apb(1'b1, ADDR_ENABLES_0, 32'h0);
      apb(1'b1, ADDR_ENABLES_1, 32'h0);
      apb(1'b1, ADDR_FLAGS_0, 32'h0);
      apb(1'b1, ADDR_IRQ_STATUS, 32'hffff);
      apb(1'b1, ADDR_IRQ_MASK, 32'h1 << EVT_NEW_PEND);
      irq_is(1'b0);
      u_per.raise(0, 0);
      irq_is(1'b1);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      irq_is(1'b0);
      apb(1'b1, 12'h01c, 32'hffff);
      rdc(ADDR_IRQ_STATUS, (32'h1 << EVT_NEW_PEND) | (32'h1 << EVT_BAD_ADDR));
      apb(1'b1, ADDR_IRQ_MASK, 32'h1 << EVT_BAD_ADDR);
      irq_is(1'b1);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1 << EVT_BAD_ADDR);
      irq_is(1'b0);
      rdc(ADDR_IRQ_STATUS, 32'h1 << EVT_NEW_PEND);
      $display("test irq done");
      close_out();
   end
endmodule
`default_nettype wire
